// ==== verif/hpcfg_cfg_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module hpcfg_cfg_host
   import hpcfg_pkg::*;
(
   input wire logic clk_i, // Clock.
   output hpcfg_wr_s wr_o  // Byte write.
);
   initial wr_o = '0;
   // Writes one byte; a legal write keeps the configuring party's limits.
   task automatic put(input logic [7:0] a, input logic [7:0] d,
      input logic ok);
      logic [7:0] v;
      v = d;
      if (ok && a inside {8'h08, 8'h09, 8'h0a})
         v[0] = 1'b0;
      if (ok && a == 8'h0b && v > 8'h32)
         v = 8'h32;
      @(posedge clk_i);
      wr_o <= '{we: 1'b1, addr: a, wdata: v};
      @(posedge clk_i);
      wr_o <= '0;
   endtask
endmodule // hpcfg_cfg_host
`default_nettype wire

// ==== verif/hpcfg_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module hpcfg_checker
   import hpcfg_pkg::*;
#(
   parameter int PORTS = 7
)
(
   input wire logic clk_i,              // Clock.
   input wire logic reset_i,            // Reset.
   input wire logic [7:0] rd_addr_i,    // Read address.
   input wire logic [7:0] rd_data_o,    // Read data.
   input wire logic [PORTS:1] oc_raw_i, // Raw overcurrent.
   input wire hpcfg_cfg_s cfg_o,        // Settings.
   input wire logic [PORTS:1] port_enable_o, // Port available.
   input wire logic [PORTS:1] oc_flag_o, // Filtered overcurrent.
   input wire logic mode_change_o       // Mode pulse.
);
   logic [16:0] hi_cnt_reg;
   logic [16:0] hi_cnt_next;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   // Counts how long port 1 overcurrent has been high, saturating.
   always_comb
   begin
      hi_cnt_next = '0;
      if (oc_raw_i[1])
         hi_cnt_next = (&hi_cnt_reg) ? hi_cnt_reg : hi_cnt_reg + 17'h1;
   end
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         hi_cnt_reg <= '0;
      else
         hi_cnt_reg <= hi_cnt_next;
   end
   port_en_a:
      assert property (port_enable_o == ~cfg_o.port_off[PORTS:1])
      else $error("port enable wrong");
   rsvd_bit_a:
      assert property (rd_addr_i inside {8'h08, 8'h09, 8'h0a} |=> !rd_data_o[0])
      else $error("reserved bit set");
   fixed_rd_a:
      assert property ($past(rd_addr_i) == 8'h08 |-> rd_data_o == cfg_o.port_fixed)
      else $error("fixed mask differs");
   sp_draw_a:
      assert property (cfg_o.self_powered && $past(rd_addr_i) == 8'h0b
         |-> rd_data_o == cfg_o.max_draw) else $error("self draw differs");
   sp_off_a:
      assert property (cfg_o.self_powered && $past(rd_addr_i) == 8'h09
         |-> rd_data_o == cfg_o.port_off) else $error("self mask differs");
   oc_early_a:
      assert property ($rose(oc_flag_o[1]) |-> hi_cnt_reg >= 17'd1000)
      else $error("overcurrent too early");
   oc_late_a:
      assert property (hi_cnt_reg > 17'd60010 |-> oc_flag_o[1])
      else $error("overcurrent too late");
   mode_pulse_a:
      assert property (mode_change_o |-> $changed(cfg_o.self_powered))
      else $error("mode pulse wrong");
   cover property ($rose(oc_flag_o[1]));
   cover property (mode_change_o && !cfg_o.self_powered);
   cover property (cfg_o.self_powered && port_enable_o != '1);
endmodule // hpcfg_checker
bind hpcfg_bank hpcfg_checker #(.PORTS(PORTS)) u_hpcfg_checker (
   .clk_i(clk_i), .reset_i(reset_i), .rd_addr_i(rd_addr_i),
   .rd_data_o(rd_data_o), .oc_raw_i(oc_raw_i), .cfg_o(cfg_o),
   .port_enable_o(port_enable_o), .oc_flag_o(oc_flag_o),
   .mode_change_o(mode_change_o));
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "hpcfg_map.svh"
module tb import hpcfg_pkg::*;;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   hpcfg_wr_s wr_i;
   logic [7:0] rd_addr_i = 8'h00;
   logic [7:0] rd_data_o;
   logic sel_i = 1'b1;
   logic sense_i = 1'b1;
   logic [7:1] oc_i = 7'h00;
   hpcfg_cfg_s cfg_o;
   logic [7:1] pen_o;
   logic [7:1] ocf_o;
   logic chg_o;
   int n_chg = 0;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   always #50 clk_i = ~clk_i;
   hpcfg_bank u_hpcfg_bank (.clk_i(clk_i), .reset_i(reset_i), .wr_i(wr_i),
      .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
      .power_source_select_i(sel_i), .local_supply_sense_i(sense_i),
      .oc_raw_i(oc_i), .cfg_o(cfg_o), .port_enable_o(pen_o),
      .oc_flag_o(ocf_o), .mode_change_o(chg_o));
   always @(posedge clk_i)
      if (chg_o === 1'b1)
         n_chg++;
   hpcfg_cfg_host u_hpcfg_cfg_host (.clk_i(clk_i), .wr_o(wr_i));
   task automatic test_done();
      if (n_fail == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, g);
      num_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rd(input logic [7:0] a, e);
      @(posedge clk_i);
      rd_addr_i <= a;
      @(posedge clk_i);
      #1 chk("rd_data", e, rd_data_o);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic t_defaults();
      logic [7:0] ex [7] = '{8'h90, 8'h00, 8'h00, 8'h00, 8'h01, 8'h64, 8'h00};
      for (int i = 0; i < 7; i++)
         rd(8'h07 + i[7:0], ex[i]);
   endtask
   task automatic t_ports();
      int n0;
      n0 = n_chg;
      u_hpcfg_cfg_host.put(8'h09, 8'he0, 1'b1);
      u_hpcfg_cfg_host.put(8'h0a, 8'h0e, 1'b1);
      u_hpcfg_cfg_host.put(8'h08, 8'h83, 1'b0);
      wt(2);
      chk("fixed", 8'h82, cfg_o.port_fixed);
      chk("self ports", 8'h0f, {1'b0, pen_o});
      n0 = n_chg;
      sense_i <= 1'b0;
      wt(6);
      chk("mode pulses", 8'h01, 8'(n_chg - n0));
      chk("bus ports", 8'h78, {1'b0, pen_o});
      chk("bus draw", 8'h64, cfg_o.max_draw);
      sense_i <= 1'b1;
      wt(6);
      chk("self draw", 8'h01, cfg_o.max_draw);
      u_hpcfg_cfg_host.put(8'h0b, 8'h33, 1'b1);
      wt(2);
      chk("limited draw", 8'h32, cfg_o.max_draw);
   endtask
   task automatic t_auto();
      u_hpcfg_cfg_host.put(8'h07, 8'h18, 1'b1);
      sense_i <= 1'b0;
      wt(6);
      chk("compound", 8'h01, {7'h0, cfg_o.compound});
      chk("held self", 8'h01, {7'h0, cfg_o.self_powered});
      sel_i <= 1'b0;
      wt(6);
      chk("chosen bus", 8'h00, {7'h0, cfg_o.self_powered});
      u_hpcfg_cfg_host.put(8'h07, 8'h90, 1'b1);
      sense_i <= 1'b1;
      wt(6);
      chk("sensed self", 8'h01, {7'h0, cfg_o.self_powered});
   endtask
   task automatic t_oc(input logic [1:0] code, input int lim);
      int n = 0;
      u_hpcfg_cfg_host.put(8'h07, {2'b10, code, 4'h0}, 1'b1);
      oc_i <= 7'h7f;
      while (ocf_o !== 7'h7f && n < 70000)
      begin
         wt(1);
         n++;
      end
      chk("oc delay", 8'h01, {7'h0, n >= lim && n <= lim + 6});
      oc_i <= 7'h00;
      wt(4);
      chk("oc clear", 8'h00, {1'b0, ocf_o});
   endtask
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         n_fail++;
         test_done();
      end
   end
   initial
   begin
      repeat (12) @(posedge clk_i);
      reset_i <= 1'b0;
      t_defaults();
      t_ports();
      t_auto();
      t_oc(2'b00, `HPCFG_US2CYC(`HPCFG_OCD0_US));
      t_oc(2'b01, `HPCFG_US2CYC(`HPCFG_OCD1_US));
      t_oc(2'b11, `HPCFG_US2CYC(`HPCFG_OCD3_US));
      test_done();
   end
endmodule // tb
`default_nettype wire

// ==== verilog/hpcfg_bank.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "hpcfg_map.svh"
module hpcfg_bank
   import hpcfg_pkg::*;
#(
   parameter int PORTS = 7,
   parameter int CW = 16
)
(
   input wire logic clk_i,                 // Core clock.
   input wire logic reset_i,               // Asynchronous reset, high.
   input wire hpcfg_wr_s wr_i,             // Byte write from loader.
   input wire logic [7:0] rd_addr_i,       // Byte read address.
   output logic [7:0] rd_data_o,           // Registered read data.
   input wire logic power_source_select_i, // Configured self(1)/bus(0).
   input wire logic local_supply_sense_i,  // Local supply pin, async.
   input wire logic [PORTS:1] oc_raw_i,    // Port overcurrent pins, async.
   output hpcfg_cfg_s cfg_o,               // Settings in effect.
   output logic [PORTS:1] port_enable_o,   // Port available.
   output logic [PORTS:1] oc_flag_o,       // Filtered overcurrent.
   output logic mode_change_o              // Pulse on power mode change.
);
   logic [7:0] opt2_reg, opt2_next;
   logic [7:0] fixed_reg, fixed_next;
   logic [7:0] sp_off_reg, sp_off_next;
   logic [7:0] bp_off_reg, bp_off_next;
   logic [7:0] sp_max_reg, sp_max_next;
   logic [7:0] bp_max_reg, bp_max_next;
   logic [7:0] rd_reg, rd_next;
   logic self_reg, self_next;
   hpcfg_cfg_s cfg_reg, cfg_next;
   logic chg_reg, chg_next;
   logic [PORTS:1] oc_sync;
   logic sense_sync;
   logic mode_self;
   logic [7:0] off_sel;

   hpcfg_sync u_sense_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(local_supply_sense_i),
      .q_o(sense_sync)
   );

   genvar g;
   generate
      for (g = 1; g <= PORTS; g++)
      begin : g_port
         hpcfg_sync u_oc_sync (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .d_i(oc_raw_i[g]),
            .q_o(oc_sync[g])
         );
         hpcfg_oc_filter #(.CW(CW)) u_oc_filt (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .raw_i(oc_sync[g]),
            .sel_i(hpcfg_ocd_e'(opt2_reg[`HPCFG_BIT_OCD_HI:`HPCFG_BIT_OCD_LO])),
            .flag_o(oc_flag_o[g])
         );
      end
   endgenerate

   // Register writes; reserved bits are forced to zero on entry.
   always_comb
   begin
      opt2_next = opt2_reg;
      fixed_next = fixed_reg;
      sp_off_next = sp_off_reg;
      bp_off_next = bp_off_reg;
      sp_max_next = sp_max_reg;
      bp_max_next = bp_max_reg;
      if (wr_i.we)
      begin
         case (wr_i.addr)
            `HPCFG_OFS_OPT2: opt2_next = wr_i.wdata & `HPCFG_OPT2_WMASK;
            `HPCFG_OFS_FIXED: fixed_next = wr_i.wdata & `HPCFG_PORT_WMASK;
            `HPCFG_OFS_SP_OFF: sp_off_next = wr_i.wdata & `HPCFG_PORT_WMASK;
            `HPCFG_OFS_BP_OFF: bp_off_next = wr_i.wdata & `HPCFG_PORT_WMASK;
            `HPCFG_OFS_SP_MAX: sp_max_next = wr_i.wdata;
            `HPCFG_OFS_BP_MAX: bp_max_next = wr_i.wdata;
            default: ;
         endcase
      end
      case (rd_addr_i)
         `HPCFG_OFS_OPT2: rd_next = opt2_reg;
         `HPCFG_OFS_FIXED: rd_next = fixed_reg;
         `HPCFG_OFS_SP_OFF: rd_next = sp_off_reg;
         `HPCFG_OFS_BP_OFF: rd_next = bp_off_reg;
         `HPCFG_OFS_SP_MAX: rd_next = sp_max_reg;
         `HPCFG_OFS_BP_MAX: rd_next = bp_max_reg;
         default: rd_next = 8'h00;
      endcase
   end

   // Power mode: sense pin when auto switching is on, else the select bit.
   always_comb
   begin
      if (opt2_reg[`HPCFG_BIT_AUTO])
         mode_self = sense_sync;
      else
         mode_self = power_source_select_i;
      self_next = mode_self;
      // The pulse lines up with the edge at which cfg_o shows the new mode.
      chg_next = (self_reg != cfg_reg.self_powered);
      off_sel = self_reg ? sp_off_reg : bp_off_reg;
      cfg_next.self_powered = self_reg;
      cfg_next.port_off = off_sel & `HPCFG_PORT_WMASK;
      cfg_next.port_fixed = fixed_reg & `HPCFG_PORT_WMASK;
      cfg_next.max_draw = self_reg ? sp_max_reg : bp_max_reg;
      cfg_next.compound = opt2_reg[`HPCFG_BIT_COMPOUND];
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         opt2_reg <= `HPCFG_RST_OPT2;
         fixed_reg <= `HPCFG_RST_FIXED;
         sp_off_reg <= `HPCFG_RST_SP_OFF;
         bp_off_reg <= `HPCFG_RST_BP_OFF;
         sp_max_reg <= `HPCFG_RST_SP_MAX;
         bp_max_reg <= `HPCFG_RST_BP_MAX;
         rd_reg <= 8'h00;
         self_reg <= 1'b0;
         chg_reg <= 1'b0;
         cfg_reg <= '0;
      end
      else
      begin
         opt2_reg <= opt2_next;
         fixed_reg <= fixed_next;
         sp_off_reg <= sp_off_next;
         bp_off_reg <= bp_off_next;
         sp_max_reg <= sp_max_next;
         bp_max_reg <= bp_max_next;
         rd_reg <= rd_next;
         self_reg <= self_next;
         chg_reg <= chg_next;
         cfg_reg <= cfg_next;
      end
   end

   assign rd_data_o = rd_reg;
   assign cfg_o = cfg_reg;
   assign port_enable_o = ~cfg_reg.port_off[PORTS:1];
   assign mode_change_o = chg_reg;
endmodule // hpcfg_bank
`default_nettype wire

// ==== verilog/hpcfg_map.svh ====
`ifndef HPCFG_MAP_SVH
`define HPCFG_MAP_SVH
`define HPCFG_OFS_OPT2 8'h07
`define HPCFG_OFS_FIXED 8'h08
`define HPCFG_OFS_SP_OFF 8'h09
`define HPCFG_OFS_BP_OFF 8'h0a
`define HPCFG_OFS_SP_MAX 8'h0b
`define HPCFG_OFS_BP_MAX 8'h0c
`define HPCFG_BIT_AUTO 7
`define HPCFG_BIT_OCD_HI 5
`define HPCFG_BIT_OCD_LO 4
`define HPCFG_BIT_COMPOUND 3
`define HPCFG_OPT2_WMASK 8'hb8
`define HPCFG_PORT_WMASK 8'hfe
`define HPCFG_RST_OPT2 8'h90
`define HPCFG_RST_FIXED 8'h00
`define HPCFG_RST_SP_OFF 8'h00
`define HPCFG_RST_BP_OFF 8'h00
`define HPCFG_RST_SP_MAX 8'h01
`define HPCFG_RST_BP_MAX 8'h64
`define HPCFG_CLK_KHZ 10000
`define HPCFG_OCD0_US 100
`define HPCFG_OCD1_US 2000
`define HPCFG_OCD2_US 4000
`define HPCFG_OCD3_US 6000
`define HPCFG_US2CYC(us) (((us) * `HPCFG_CLK_KHZ) / 1000)
`endif

// ==== verilog/hpcfg_oc_filter.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "hpcfg_map.svh"
module hpcfg_oc_filter
   import hpcfg_pkg::*;
#(
   parameter int CW = 16
)
(
   input wire logic clk_i,        // Core clock.
   input wire logic reset_i,      // Asynchronous reset.
   input wire logic raw_i,        // Synchronised overcurrent level.
   input wire hpcfg_ocd_e sel_i,  // Filter delay choice.
   output logic flag_o            // Filtered overcurrent level.
);
   localparam logic [CW-1:0] C0 = CW'(`HPCFG_US2CYC(`HPCFG_OCD0_US));
   localparam logic [CW-1:0] C1 = CW'(`HPCFG_US2CYC(`HPCFG_OCD1_US));
   localparam logic [CW-1:0] C2 = CW'(`HPCFG_US2CYC(`HPCFG_OCD2_US));
   localparam logic [CW-1:0] C3 = CW'(`HPCFG_US2CYC(`HPCFG_OCD3_US));
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic flag_reg;
   logic flag_next;
   logic [CW-1:0] limit;
   always_comb
   begin
      case (sel_i)
         HPCFG_OCD_0P1MS: limit = C0;
         HPCFG_OCD_2MS: limit = C1;
         HPCFG_OCD_4MS: limit = C2;
         HPCFG_OCD_6MS: limit = C3;
         default: limit = C1;
      endcase
      cnt_next = cnt_reg;
      flag_next = flag_reg;
      if (!raw_i)
      begin
         cnt_next = '0;
         flag_next = 1'b0;
      end
      else if (cnt_reg >= limit)
         flag_next = 1'b1;
      else
         cnt_next = cnt_reg + 1'b1;
   end
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         cnt_reg <= '0;
         flag_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         flag_reg <= flag_next;
      end
   end
   assign flag_o = flag_reg;
endmodule // hpcfg_oc_filter
`default_nettype wire

// ==== verilog/hpcfg_pkg.sv ====
package hpcfg_pkg;
   typedef enum logic [1:0] {
      HPCFG_OCD_0P1MS,
      HPCFG_OCD_2MS,
      HPCFG_OCD_4MS,
      HPCFG_OCD_6MS
   } hpcfg_ocd_e;
   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } hpcfg_wr_s;
   typedef struct packed {
      logic [7:0] port_off;
      logic [7:0] port_fixed;
      logic [7:0] max_draw;
      logic compound;
      logic self_powered;
   } hpcfg_cfg_s;
endpackage

// ==== verilog/hpcfg_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module hpcfg_sync
   import hpcfg_pkg::*;
(
   input wire logic clk_i,   // Core clock.
   input wire logic reset_i, // Asynchronous reset.
   input wire logic d_i,     // Level from outside the clock domain.
   output logic q_o          // Synchronised level.
);
   logic meta_reg;
   logic sync_reg;
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end
   assign q_o = sync_reg;
endmodule // hpcfg_sync
`default_nettype wire
